// [drt_raster_timing.sv]
// Raster timing generator top: registers, counters, region outputs, events
// How it works
// R1: line length is bits 27:16 of line_size_config, total pixels minus one.
// R2: software loads line length as pixels per line minus one.
// R3: visible pixels per line is bits 11:0, width minus one, from zero.
// R4: software keeps visible pixels below the line length.
// R5: software keeps visible width a multiple of 8 or 4 per depth.
// R6: horizontal blanking begins after line-blank-begin, bits 27:16.
// R7: right border spans last visible pixel to blank begin, else none.
// R8: software sets blank begin from visible width to below line length.
// R9: horizontal blanking ends at line-blank-finish, bits 11:0.
// R10: no left border when blank finish equals line length.
// R11: software sets blank finish above blank begin, up to line length.
// R12: horizontal sync starts at line-sync-begin, bits 27:16.
// R13: horizontal sync ends at line-sync-finish, bits 11:0.
// R14: frame length is bits 27:16 of frame_size_config, lines minus one.
// R15: software loads frame length as lines per frame minus one.
// R16: visible lines per frame is bits 11:0, count minus one, from zero.
// R17: line-blank event flag, status bit 7, set as line blanking begins.
// R18: frame-blank event flag, status bit 6, set as frame blanking begins.
// R19: vertical blanking begins after frame-blank-begin, bits 27:16.
// R20: pixel counter wraps after line length; line counter after frame.
// R21: sync active from sync begin up to but excluding sync finish.
`timescale 1ns/1ps
`default_nettype none
module drt_raster_timing (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output var  logic [31:0] rd_data,
  output var  logic [11:0] pix_x,
  output var  logic [11:0] pix_y,
  output var  logic        visible,
  output var  logic        hblank,
  output var  logic        vblank,
  output var  logic        hsync,
  output var  logic        border
);
  logic [31:0] line_size_config;
  logic [31:0] line_blank_config;
  logic [31:0] line_sync_config;
  logic [31:0] frame_size_config;
  logic [31:0] frame_blank_config;
  logic [1:0]  event_flag;
  logic [1:0]  event_start;
  logic [1:0]  event_clear;
  logic        hblank_prev;
  logic        vblank_prev;
  logic [31:0] next_rd_data;
  logic [31:0] status_word;

  drt_cnt_if bus ();

  assign bus.h_total  = drt_pkg::drt_hi(line_size_config);  // R1
  assign bus.h_active = drt_pkg::drt_lo(line_size_config);  // R3
  assign bus.hb_begin = drt_pkg::drt_hi(line_blank_config);  // R6
  assign bus.hb_end   = drt_pkg::drt_lo(line_blank_config);  // R9
  assign bus.hs_begin = drt_pkg::drt_hi(line_sync_config);  // R12
  assign bus.hs_end   = drt_pkg::drt_lo(line_sync_config);  // R13
  assign bus.v_total  = drt_pkg::drt_hi(frame_size_config);  // R14
  assign bus.v_active = drt_pkg::drt_lo(frame_size_config);  // R16
  assign bus.vb_begin = drt_pkg::drt_hi(frame_blank_config);  // R19
  assign bus.vb_end   = drt_pkg::drt_lo(frame_blank_config);

  drt_raster_count u_count (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .bus (bus)
  );

  drt_region_decode u_decode (
    .bus (bus)
  );

  // Timing registers, reserved bits held at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_size_config   <= drt_pkg::CFG_RESET;
      line_blank_config  <= drt_pkg::CFG_RESET;
      line_sync_config   <= drt_pkg::CFG_RESET;
      frame_size_config  <= drt_pkg::CFG_RESET;
      frame_blank_config <= drt_pkg::CFG_RESET;
    end else if (ce && wr_en) begin
      case (addr)
        drt_pkg::LINE_SIZE_ADDR: begin
          line_size_config <= wr_data & drt_pkg::FIELD_MASK;  // R1 R3
        end
        drt_pkg::LINE_BLNK_ADDR: begin
          line_blank_config <= wr_data & drt_pkg::FIELD_MASK;
        end
        drt_pkg::LINE_SYNC_ADDR: begin
          line_sync_config <= wr_data & drt_pkg::FIELD_MASK;
        end
        drt_pkg::FRM_SIZE_ADDR: begin
          frame_size_config <= wr_data & drt_pkg::FIELD_MASK;  // R14 R16
        end
        drt_pkg::FRM_BLNK_ADDR: begin
          frame_blank_config <= wr_data & drt_pkg::FIELD_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Region outputs registered straight from the decoder
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_x   <= drt_pkg::CNT_ZERO;
      pix_y   <= drt_pkg::CNT_ZERO;
      visible <= 1'b0;
      hblank  <= 1'b0;
      vblank  <= 1'b0;
      hsync   <= 1'b0;
      border  <= 1'b0;
    end else if (ce) begin
      pix_x   <= bus.h_count;
      pix_y   <= bus.v_count;
      visible <= bus.visible;
      hblank  <= bus.hblank;
      vblank  <= bus.vblank;
      hsync   <= bus.hsync;  // R21
      border  <= bus.border;
    end
  end

  // Previous blank levels for start detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hblank_prev <= 1'b0;
      vblank_prev <= 1'b0;
    end else if (ce) begin
      hblank_prev <= bus.hblank;
      vblank_prev <= bus.vblank;
    end
  end

  assign event_start[1] = bus.hblank && !hblank_prev;  // R17
  assign event_start[0] = bus.vblank && !vblank_prev;  // R18

  // Sticky event flags, write one clears, a new start beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_event
      localparam int BIT = (gi == 1) ? drt_pkg::LINE_EV_BIT
                                     : drt_pkg::FRAME_EV_BIT;
      assign event_clear[gi] = wr_en && (addr == drt_pkg::STATUS_ADDR)
                               && wr_data[BIT];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          event_flag[gi] <= 1'b0;
        end else if (ce) begin
          if (event_start[gi]) begin
            event_flag[gi] <= 1'b1;  // R17 R18
          end else if (event_clear[gi]) begin
            event_flag[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[drt_pkg::LINE_EV_BIT]  = event_flag[1];  // R17
    status_word[drt_pkg::FRAME_EV_BIT] = event_flag[0];  // R18
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    case (addr)
      drt_pkg::STATUS_ADDR:    next_rd_data = status_word;
      drt_pkg::LINE_SIZE_ADDR: next_rd_data = line_size_config;
      drt_pkg::LINE_BLNK_ADDR: next_rd_data = line_blank_config;
      drt_pkg::LINE_SYNC_ADDR: next_rd_data = line_sync_config;
      drt_pkg::FRM_SIZE_ADDR:  next_rd_data = frame_size_config;
      drt_pkg::FRM_BLNK_ADDR:  next_rd_data = frame_blank_config;
      default:                 next_rd_data = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else if (ce) begin
      rd_data <= rd_en ? next_rd_data : 32'h0000_0000;
    end
  end

  a_pix_wrap: assert property (  // R20
    @(posedge clk) disable iff (rst)
    ce && (bus.h_count == bus.h_total) |=> (bus.h_count == 12'h000))
    else $error("pixel counter did not wrap after line length");

  a_pix_step: assert property (  // R20
    @(posedge clk) disable iff (rst)
    ce && (bus.h_count < bus.h_total) && $stable(line_size_config)
    |=> (bus.h_count == $past(bus.h_count) + 12'h001))
    else $error("pixel counter did not advance by one");

  a_line_step: assert property (  // R20
    @(posedge clk) disable iff (rst)
    ce && bus.line_wrap && (bus.v_count < bus.v_total)
    |=> (bus.v_count == $past(bus.v_count) + 12'h001))
    else $error("line counter did not advance on pixel wrap");

  a_line_hold: assert property (  // R20
    @(posedge clk) disable iff (rst)
    !bus.line_wrap |=> $stable(bus.v_count))
    else $error("line counter moved without a pixel wrap");

  a_sync_window: assert property (  // R21
    @(posedge clk) disable iff (rst)
    ce |=> (hsync == (($past(bus.h_count) >= $past(bus.hs_begin))
                      && ($past(bus.h_count) < $past(bus.hs_end)))))
    else $error("line sync outside its begin and finish window");

  a_hblank_range: assert property (  // R6
    @(posedge clk) disable iff (rst)
    ce ##1 (pix_x > drt_pkg::drt_hi(line_blank_config))
           && (pix_x <= drt_pkg::drt_lo(line_blank_config))
           && $stable(line_blank_config) |-> hblank)
    else $error("line blank missing inside its window");

  a_line_event: assert property (  // R17
    @(posedge clk) disable iff (rst)
    ce && bus.hblank && !hblank_prev |=> event_flag[1])
    else $error("line blank start did not set its event flag");

  a_frame_event: assert property (  // R18
    @(posedge clk) disable iff (rst)
    ce && bus.vblank && !vblank_prev |=> event_flag[0])
    else $error("frame blank start did not set its event flag");

  a_vis_span: assert property (  // R3
    @(posedge clk) disable iff (rst)
    ce && visible |-> (pix_x <= drt_pkg::drt_lo($past(line_size_config))))
    else $error("visible flagged beyond last visible pixel");

  a_vblank_range: assert property (  // R19
    @(posedge clk) disable iff (rst)
    ce ##1 (pix_y > drt_pkg::drt_hi(frame_blank_config))
           && (pix_y <= drt_pkg::drt_lo(frame_blank_config))
           && $stable(frame_blank_config) |-> vblank)
    else $error("frame blank missing inside its window");

  a_vblank_outside: assert property (  // R19
    @(posedge clk) disable iff (rst)
    ce ##1 ((pix_y <= drt_pkg::drt_hi(frame_blank_config))
            || (pix_y > drt_pkg::drt_lo(frame_blank_config)))
           && $stable(frame_blank_config) |-> !vblank)
    else $error("frame blank outside its window");

  a_hblank_outside: assert property (  // R6 R9
    @(posedge clk) disable iff (rst)
    ce ##1 ((pix_x <= drt_pkg::drt_hi(line_blank_config))
            || (pix_x > drt_pkg::drt_lo(line_blank_config)))
           && $stable(line_blank_config) |-> !hblank)
    else $error("line blank outside its window");

  a_vis_window: assert property (  // R3 R16
    @(posedge clk) disable iff (rst)
    ce ##1 (pix_x <= drt_pkg::drt_lo(line_size_config))
           && (pix_y <= drt_pkg::drt_lo(frame_size_config))
           && $stable(line_size_config)
           && $stable(frame_size_config) |-> visible)
    else $error("visible missing inside the active area");

  a_right_border: assert property (  // R7
    @(posedge clk) disable iff (rst)
    ce ##1 (pix_x > drt_pkg::drt_lo(line_size_config))
           && (pix_x <= drt_pkg::drt_hi(line_blank_config))
           && !hblank && !vblank && $stable(line_size_config)
           && $stable(line_blank_config) |-> border)
    else $error("right border missing");

  a_left_border: assert property (  // R10
    @(posedge clk) disable iff (rst)
    ce ##1 (pix_x > drt_pkg::drt_lo(line_blank_config))
           && (pix_x <= drt_pkg::drt_hi(line_size_config))
           && !visible && !hblank && !vblank
           && $stable(line_size_config)
           && $stable(line_blank_config) |-> border)
    else $error("left border missing");

  a_frame_wrap: assert property (  // R20
    @(posedge clk) disable iff (rst)
    ce && bus.line_wrap && (bus.v_count == bus.v_total)
    |=> (bus.v_count == 12'h000))
    else $error("line counter did not wrap after frame length");

  a_read_value: assert property (  // R1 R3
    @(posedge clk) disable iff (rst)
    ce && rd_en && (addr == drt_pkg::LINE_SIZE_ADDR)
    |=> (rd_data == $past(line_size_config)))
    else $error("read data differs from the line size register");

  a_read_idle: assert property (
    @(posedge clk) disable iff (rst)
    ce && !rd_en |=> (rd_data == 32'h0000_0000))
    else $error("read data stood beyond its cycle");

  a_ce_freeze: assert property (
    @(posedge clk) disable iff (rst)
    !ce |=> $stable(pix_x) && $stable(pix_y) && $stable(event_flag)
            && $stable(rd_data) && $stable(hsync))
    else $error("state moved while clock enable was low");
endmodule : drt_raster_timing
`default_nettype wire

// [drt_pkg.sv]
// Constants, register map and shared decode helpers for the raster timer
package drt_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          CNT_W          = 12;
  localparam logic [7:0]  STATUS_ADDR    = 8'h04;
  localparam logic [7:0]  LINE_SIZE_ADDR = 8'h08;
  localparam logic [7:0]  LINE_BLNK_ADDR = 8'h0C;
  localparam logic [7:0]  LINE_SYNC_ADDR = 8'h10;
  localparam logic [7:0]  FRM_SIZE_ADDR  = 8'h14;
  localparam logic [7:0]  FRM_BLNK_ADDR  = 8'h18;
  localparam int          HI_MSB         = 27;
  localparam int          HI_LSB         = 16;
  localparam int          LO_MSB         = 11;
  localparam int          LO_LSB         = 0;
  localparam logic [31:0] FIELD_MASK     = 32'h0FFF_0FFF;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam int          LINE_EV_BIT    = 7;
  localparam int          FRAME_EV_BIT   = 6;
  localparam logic [11:0] CNT_ZERO       = 12'h000;
  localparam logic [11:0] CNT_ONE        = 12'h001;

  // High field of a timing register
  function automatic logic [11:0] drt_hi(input logic [31:0] r);
    drt_hi = r[HI_MSB:HI_LSB];
  endfunction : drt_hi

  // Low field of a timing register
  function automatic logic [11:0] drt_lo(input logic [31:0] r);
    drt_lo = r[LO_MSB:LO_LSB];
  endfunction : drt_lo

  // Index lies after lo and up to hi inclusive
  function automatic logic drt_after(input logic [11:0] x,
                                     input logic [11:0] lo,
                                     input logic [11:0] hi);
    drt_after = (x > lo) && (x <= hi);
  endfunction : drt_after
endpackage : drt_pkg

// [drt_cnt_if.sv]
// Carrier between the raster timer, its counters and its region decoder
`timescale 1ns/1ps
`default_nettype none
interface drt_cnt_if;
  logic [11:0] h_total;
  logic [11:0] v_total;
  logic [11:0] h_count;
  logic [11:0] v_count;
  logic        line_wrap;
  logic [11:0] h_active;
  logic [11:0] hb_begin;
  logic [11:0] hb_end;
  logic [11:0] hs_begin;
  logic [11:0] hs_end;
  logic [11:0] v_active;
  logic [11:0] vb_begin;
  logic [11:0] vb_end;
  logic        visible;
  logic        hblank;
  logic        vblank;
  logic        hsync;
  logic        border;

  modport cnt (input h_total, v_total, output h_count, v_count, line_wrap);
  modport dec (input h_count, v_count, h_total, v_total, h_active, hb_begin,
               hb_end, hs_begin, hs_end, v_active, vb_begin, vb_end,
               output visible, hblank, vblank, hsync, border);
  modport top (output h_total, v_total, h_active, hb_begin, hb_end,
               hs_begin, hs_end, v_active, vb_begin, vb_end,
               input h_count, v_count, line_wrap, visible, hblank, vblank,
               hsync, border);
endinterface : drt_cnt_if
`default_nettype wire

// [drt_raster_count.sv]
// Pixel and line counters of the raster
`timescale 1ns/1ps
`default_nettype none
module drt_raster_count (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  drt_cnt_if.cnt    bus
);
  logic frame_wrap;

  // At or past total so a shrunken total never runs the full range
  assign bus.line_wrap = (bus.h_count >= bus.h_total);  // R20
  assign frame_wrap    = (bus.v_count >= bus.v_total);  // R20

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.h_count <= drt_pkg::CNT_ZERO;
    end else if (ce) begin
      if (bus.line_wrap) begin
        bus.h_count <= drt_pkg::CNT_ZERO;  // R20
      end else begin
        bus.h_count <= bus.h_count + drt_pkg::CNT_ONE;  // R20
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.v_count <= drt_pkg::CNT_ZERO;
    end else if (ce && bus.line_wrap) begin
      if (frame_wrap) begin
        bus.v_count <= drt_pkg::CNT_ZERO;  // R20
      end else begin
        bus.v_count <= bus.v_count + drt_pkg::CNT_ONE;  // R20
      end
    end
  end
endmodule : drt_raster_count
`default_nettype wire

// [drt_region_decode.sv]
// Decodes visible, blank, sync and border regions from the counters
`timescale 1ns/1ps
`default_nettype none
module drt_region_decode (
  drt_cnt_if.dec bus
);
  logic h_vis;
  logic v_vis;

  assign h_vis      = (bus.h_count <= bus.h_active);  // R3
  assign v_vis      = (bus.v_count <= bus.v_active);  // R16
  assign bus.visible = h_vis && v_vis;
  // Blank runs from after blank begin up to and including blank end
  assign bus.hblank = drt_pkg::drt_after(bus.h_count, bus.hb_begin,
                                         bus.hb_end);  // R6 R9
  assign bus.vblank = drt_pkg::drt_after(bus.v_count, bus.vb_begin,
                                         bus.vb_end);  // R19
  assign bus.hsync  = (bus.h_count >= bus.hs_begin)
                      && (bus.h_count < bus.hs_end);  // R12 R13 R21
  // Right border after last visible pixel up to blank begin, left border
  // after blank end; empty when begin equals active or end equals total
  assign bus.border = !bus.visible && !bus.hblank && !bus.vblank
                      && (drt_pkg::drt_after(bus.h_count, bus.h_active,
                                             bus.hb_begin)  // R7
                          || drt_pkg::drt_after(bus.h_count, bus.hb_end,
                                                bus.h_total)  // R10
                          || drt_pkg::drt_after(bus.v_count, bus.v_active,
                                                bus.vb_begin)
                          || drt_pkg::drt_after(bus.v_count, bus.vb_end,
                                                bus.v_total)
                          || (h_vis && v_vis));
endmodule : drt_region_decode
`default_nettype wire

// [drt_monitor.sv]
// Display output path model: measures sync and visible run lengths
`timescale 1ns/1ps
`default_nettype none
module drt_monitor (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsync,
  input  wire logic        visible,
  output var  logic [11:0] sync_len,
  output var  logic [11:0] vis_len
);
  logic [11:0] sync_run;
  logic [11:0] vis_run;

  // Length of last completed sync pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_run <= 12'h000;
      sync_len <= 12'h000;
    end else if (hsync) begin
      sync_run <= sync_run + 12'h001;
    end else if (sync_run != 12'h000) begin
      sync_len <= sync_run;
      sync_run <= 12'h000;
    end
  end

  // Length of last completed visible run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vis_run <= 12'h000;
      vis_len <= 12'h000;
    end else if (visible) begin
      vis_run <= vis_run + 12'h001;
    end else if (vis_run != 12'h000) begin
      vis_len <= vis_run;
      vis_run <= 12'h000;
    end
  end
endmodule : drt_monitor
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the raster timing generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rd_data;
  logic [11:0] pix_x;
  logic [11:0] pix_y;
  logic        visible;
  logic        hblank;
  logic        vblank;
  logic        hsync;
  logic        border;
  logic [11:0] sync_len;
  logic [11:0] vis_len;
  int          errors = 0;
  int          cmp_count = 0;

  always #4 clk = ~clk;

  drt_raster_timing uut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .pix_x(pix_x), .pix_y(pix_y), .visible(visible), .hblank(hblank),
    .vblank(vblank), .hsync(hsync), .border(border));

  drt_monitor mon (.clk(clk), .rst(rst), .hsync(hsync), .visible(visible),
    .sync_len(sync_len), .vis_len(vis_len));

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : reg_read

  // Align to the first pixel of line y
  task automatic sync_to(input logic [11:0] y);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 500) begin
        chk(32'h0, 32'h1, "raster sync timeout");
        print_verdict();
      end
    end while (!(pix_x === 12'h000 && pix_y === y));
  endtask : sync_to

  task automatic test_reset_and_fields;
    logic [7:0]  regs [6];
    logic [31:0] d;
    regs = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    foreach (regs[i]) begin
      reg_read(regs[i], d);
      chk(d, 32'h0000_0000, "reset value");
    end
    for (int i = 1; i < 6; i++) begin
      reg_write(regs[i], 32'hFFFF_FFFF);
      reg_read(regs[i], d);
      chk(d, 32'h0FFF_0FFF, "field mask");
    end
    reg_write(8'h1C, 32'h1234_5678);
    reg_read(8'h1C, d);
    chk(d, 32'h0000_0000, "unmapped read");
    $display("test_reset_and_fields done");
  endtask : test_reset_and_fields

  // 16 pixels by 6 lines; values kept legal for software side
  task automatic test_raster;
    logic [11:0] x;
    logic [11:0] y;
    logic        v;
    logic        hb;
    logic        vb;
    logic        hs;
    logic [31:0] d;
    reg_write(8'h08, 32'h000F_0007);
    reg_write(8'h0C, 32'h0009_000D);
    reg_write(8'h10, 32'h000A_000C);
    reg_write(8'h14, 32'h0005_0002);
    reg_write(8'h18, 32'h0003_0005);
    sync_to(12'h000);
    x = 12'h000;
    y = 12'h000;
    for (int i = 0; i < 192; i++) begin
      v = (x <= 12'h007) && (y <= 12'h002);
      hb = (x > 12'h009) && (x <= 12'h00D);
      vb = (y > 12'h003) && (y <= 12'h005);
      hs = (x >= 12'h00A) && (x < 12'h00C);
      chk({3'b000, pix_x, pix_y, visible, hblank, vblank, hsync, border},
          {3'b000, x, y, v, hb, vb, hs, !v && !hb && !vb},
          "raster");
      x = (x == 12'h00F) ? 12'h000 : x + 12'h001;
      if (x == 12'h000) begin
        y = (y == 12'h005) ? 12'h000 : y + 12'h001;
      end
      @(posedge clk);
      #1;
    end
    chk({20'h0, sync_len}, 32'h2, "sync width");
    chk({20'h0, vis_len}, 32'h8, "visible width");
    reg_read(8'h04, d);
    chk(d, 32'h0000_00C0, "both events");
    $display("test_raster done");
  endtask : test_raster

  task automatic test_events_and_ce;
    logic [31:0] d;
    logic [11:0] x;
    int          n;
    sync_to(12'h001);
    reg_write(8'h04, 32'h0000_00C0);
    reg_read(8'h04, d);
    chk(d, 32'h0000_0000, "event clear");
    n = 0;
    while (hblank !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, hblank}, 32'h1, "blank reached");
    reg_read(8'h04, d);
    chk(d, 32'h0000_0080, "line event only");
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    #1;
    x = pix_x;
    repeat (4) @(posedge clk);
    #1;
    chk({20'h0, pix_x}, {20'h0, x}, "frozen by ce");
    @(posedge clk);
    ce <= 1'b1;
    $display("test_events_and_ce done");
  endtask : test_events_and_ce

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_reset_and_fields();
    test_raster();
    test_events_and_ce();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
